// *** rtl/rsl_cfg.svh ***
// Constants for the reset strap latch and decoder.
// Assumes a single core clock domain; included by bare name.
`ifndef RSL_CFG_SVH
`define RSL_CFG_SVH

`define RSL_NUM_PORTS      6
`define RSL_LEVEL_W        3
// Sensed resistor level codes from the analog front end
`define RSL_LVL_200K_DOWN  3'h0
`define RSL_LVL_200K_UP    3'h1
`define RSL_LVL_10K_DOWN   3'h2
`define RSL_LVL_10K_UP     3'h3
`define RSL_LVL_10R_DOWN   3'h4
`define RSL_LVL_10R_UP     3'h5
// Reset values of latched state
`define RSL_RST_LEVEL      3'h0
`define RSL_RST_STRAPS     6'h00

`endif

// *** rtl/rsl_pkg.sv ***
// Types shared by the strap latch files.
// Assumes rsl_cfg.svh supplies the numeric constants.
package rsl_pkg;

	typedef enum logic [2:0]
	{
		RSL_MODE_BRIDGE_MASTER,
		RSL_MODE_CONFIG_SLAVE,
		RSL_MODE_RSVD3,
		RSL_MODE_RSVD4,
		RSL_MODE_RSVD5,
		RSL_MODE_RSVD6
	} rsl_mode_t;

	typedef enum logic [1:0]
	{
		RSL_ST_HELD,
		RSL_ST_CAPTURE,
		RSL_ST_LOCKED
	} rsl_state_t;

endpackage

// *** rtl/rsl_sync3.sv ***
// Three-stage synchroniser for pin inputs with agreement filter.
// Assumes inputs are asynchronous to i_clk.
`timescale 1ns/1ps
`include "rsl_cfg.svh"

module rsl_sync3
#(
	parameter int W = 1
)
(
	// Clock
	input  wire logic         i_clk,
	input  wire logic         i_sys_rst,
	input  wire logic         i_ce,
	// Data
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);

	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;
	logic [W-1:0] o_sync_next;

	// A bit changes only when the second and third stages agree
	genvar g;
	generate
		for (g = 0; g < W; g++)
		begin : g_bit
			assign o_sync_next[g] = (s2_reg[g] == s3_reg[g]) ? s3_reg[g] : o_sync[g];
		end
	endgenerate

	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			o_sync <= '0;
		end
		else if (i_ce)
		begin
			s1_reg <= i_async;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			o_sync <= o_sync_next;
		end
	end

endmodule

// *** rtl/rsl_strap_latch.sv ***
// Strap latch and decoder: captures configuration straps at reset release.
// Assumes strap levels are settled before release and POR is a pin input.
`timescale 1ns/1ps
`include "rsl_cfg.svh"

module rsl_strap_latch
#(
	parameter int NP = `RSL_NUM_PORTS,
	parameter int LW = `RSL_LEVEL_W
)
(
	// Clock and reset
	input  wire logic              i_clk,
	input  wire logic              i_sys_rst,
	input  wire logic              i_ce,
	// Reset sources from pins
	input  wire logic              i_por_n,
	input  wire logic              i_chip_rst_n,
	// Strap pins
	input  wire logic [LW-1:0]     i_mode_strap_level,
	input  wire logic [NP-1:0]     i_port_dplus_off_strap,
	input  wire logic [NP-1:0]     i_port_dminus_off_strap,
	// Reset and status
	output logic                   o_core_rst,
	output logic                   o_straps_valid,
	// Decoded mode
	output rsl_pkg::rsl_mode_t     o_mode,
	output logic                   o_bridge_master_setting,
	output logic                   o_config_slave_setting,
	output logic                   o_mode_reserved,
	// Per-port results
	output logic [NP-1:0]          o_dplus_disabled,
	output logic [NP-1:0]          o_dminus_disabled,
	output logic [NP-1:0]          o_usb2_port_disabled,
	output logic [NP-1:0]          o_ss_port_disabled
);

	localparam int SW = LW + 2 * NP + 2;

	// ==========================================================
	// Pin synchronisation
	// ==========================================================
	logic [SW-1:0] pins_async;
	logic [SW-1:0] pins_sync;

	assign pins_async = {i_por_n, i_chip_rst_n, i_mode_strap_level,
		i_port_dplus_off_strap, i_port_dminus_off_strap};

	rsl_sync3 #(.W(SW)) u_sync
	(
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_ce      (i_ce),
		.i_async   (pins_async),
		.o_sync    (pins_sync)
	);

	wire           rst_active_w;
	wire [LW-1:0]  level_w;
	wire [NP-1:0]  dp_w;
	wire [NP-1:0]  dm_w;

	// Either reset source holds the core
	assign rst_active_w = ~pins_sync[SW-1] | ~pins_sync[SW-2];
	assign level_w      = pins_sync[2*NP +: LW];
	assign dp_w         = pins_sync[NP +: NP];
	assign dm_w         = pins_sync[0 +: NP];

	// ==========================================================
	// Capture sequencer
	// ==========================================================
	rsl_pkg::rsl_state_t state_reg;
	rsl_pkg::rsl_state_t state_next;
	logic [LW-1:0]       level_reg;
	logic [NP-1:0]       dp_reg;
	logic [NP-1:0]       dm_reg;
	wire                 capture_w;

	// Straps are taken only on the first cycle after release
	assign capture_w = (state_reg == rsl_pkg::RSL_ST_CAPTURE);

	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			rsl_pkg::RSL_ST_HELD:
				if (!rst_active_w)
					state_next = rsl_pkg::RSL_ST_CAPTURE;
			rsl_pkg::RSL_ST_CAPTURE:
				state_next = rst_active_w ? rsl_pkg::RSL_ST_HELD : rsl_pkg::RSL_ST_LOCKED;
			rsl_pkg::RSL_ST_LOCKED:
				if (rst_active_w)
					state_next = rsl_pkg::RSL_ST_HELD;
			default:
				state_next = rsl_pkg::RSL_ST_HELD;
		endcase
	end

	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			state_reg <= rsl_pkg::RSL_ST_HELD;
		end
		else if (i_ce)
		begin
			state_reg <= state_next;
		end
	end

	// Latched copies change only at capture; later pin motion is ignored
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			level_reg <= LW'(`RSL_RST_LEVEL);
			dp_reg    <= NP'(`RSL_RST_STRAPS);
			dm_reg    <= NP'(`RSL_RST_STRAPS);
		end
		else if (i_ce && capture_w)
		begin
			level_reg <= level_w;
			dp_reg    <= dp_w;
			dm_reg    <= dm_w;
		end
	end

	// ==========================================================
	// Decode
	// ==========================================================
	rsl_pkg::rsl_mode_t mode_w;
	wire [NP-1:0]       port_off_w;

	always_comb
	begin
		mode_w = rsl_pkg::RSL_MODE_RSVD6;
		unique case (level_reg)
			`RSL_LVL_200K_DOWN: mode_w = rsl_pkg::RSL_MODE_BRIDGE_MASTER;
			`RSL_LVL_200K_UP:   mode_w = rsl_pkg::RSL_MODE_CONFIG_SLAVE;
			`RSL_LVL_10K_DOWN:  mode_w = rsl_pkg::RSL_MODE_RSVD3;
			`RSL_LVL_10K_UP:    mode_w = rsl_pkg::RSL_MODE_RSVD4;
			`RSL_LVL_10R_DOWN:  mode_w = rsl_pkg::RSL_MODE_RSVD5;
			// The 10R pull-up code and the unsensed codes fold into the last reserved setting
			default:            mode_w = rsl_pkg::RSL_MODE_RSVD6;
		endcase
	end

	genvar p;
	generate
		for (p = 0; p < NP; p++)
		begin : g_port
			assign port_off_w[p] = dp_reg[p] & dm_reg[p];
		end
	endgenerate

	// ==========================================================
	// Output registers
	// ==========================================================
	// Outputs follow the latched copies after reset, so o_bridge_master_setting is set before the first capture
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			o_core_rst              <= 1'b1;
			o_straps_valid          <= 1'b0;
			o_mode                  <= rsl_pkg::RSL_MODE_BRIDGE_MASTER;
			o_bridge_master_setting <= 1'b0;
			o_config_slave_setting  <= 1'b0;
			o_mode_reserved         <= 1'b0;
			o_dplus_disabled        <= NP'(`RSL_RST_STRAPS);
			o_dminus_disabled       <= NP'(`RSL_RST_STRAPS);
			o_usb2_port_disabled    <= NP'(`RSL_RST_STRAPS);
			o_ss_port_disabled      <= NP'(`RSL_RST_STRAPS);
		end
		else if (i_ce)
		begin
			o_core_rst              <= (state_reg != rsl_pkg::RSL_ST_LOCKED);
			o_straps_valid          <= (state_reg == rsl_pkg::RSL_ST_LOCKED);
			o_mode                  <= mode_w;
			o_bridge_master_setting <= (mode_w == rsl_pkg::RSL_MODE_BRIDGE_MASTER);
			o_config_slave_setting  <= (mode_w == rsl_pkg::RSL_MODE_CONFIG_SLAVE);
			o_mode_reserved         <= (level_reg > `RSL_LVL_200K_UP);
			o_dplus_disabled        <= dp_reg;
			o_dminus_disabled       <= dm_reg;
			o_usb2_port_disabled    <= port_off_w;
			o_ss_port_disabled      <= port_off_w;
		end
	end

	// ==========================================================
	// Checks
	// ==========================================================
	// Antecedents also sample the reset: on the release edge the outputs still take
	// their reset values, so an update is only expected from edges that saw it low
	property p_capture_after_release;
		@(posedge i_clk) disable iff (i_sys_rst)
		(!i_sys_rst && i_ce && capture_w) |=>
			(level_reg == $past(level_w)) && (dp_reg == $past(dp_w));
	endproperty
	a_capture_after_release: assert property (p_capture_after_release)
		else $error("straps not captured at release");

	property p_no_capture_in_reset;
		@(posedge i_clk) disable iff (i_sys_rst)
		(state_reg == rsl_pkg::RSL_ST_HELD) |=> $stable(dp_reg) && $stable(level_reg);
	endproperty
	a_no_capture_in_reset: assert property (p_no_capture_in_reset)
		else $error("straps changed while held in reset");

	property p_hold_locked;
		@(posedge i_clk) disable iff (i_sys_rst)
		(state_reg == rsl_pkg::RSL_ST_LOCKED) |=> $stable(dp_reg) && $stable(dm_reg);
	endproperty
	a_hold_locked: assert property (p_hold_locked)
		else $error("latched straps moved after lock");

	property p_master_mode;
		@(posedge i_clk) disable iff (i_sys_rst)
		(!i_sys_rst && i_ce && level_reg == `RSL_LVL_200K_DOWN) |=>
			o_bridge_master_setting && !o_mode_reserved;
	endproperty
	a_master_mode: assert property (p_master_mode)
		else $error("bridge master not selected");

	property p_slave_mode;
		@(posedge i_clk) disable iff (i_sys_rst)
		(!i_sys_rst && i_ce && level_reg == `RSL_LVL_200K_UP) |=>
			o_config_slave_setting && !o_bridge_master_setting;
	endproperty
	a_slave_mode: assert property (p_slave_mode)
		else $error("config slave not selected");

	property p_reserved_mode;
		@(posedge i_clk) disable iff (i_sys_rst)
		(!i_sys_rst && i_ce && level_reg >= `RSL_LVL_10K_DOWN) |=>
			o_mode_reserved && !o_config_slave_setting;
	endproperty
	a_reserved_mode: assert property (p_reserved_mode)
		else $error("reserved code selected a function");

	property p_dplus_map;
		@(posedge i_clk) disable iff (i_sys_rst)
		(!i_sys_rst && i_ce) |=>
			(o_dplus_disabled == $past(dp_reg)) && (o_dminus_disabled == $past(dm_reg));
	endproperty
	a_dplus_map: assert property (p_dplus_map)
		else $error("pin disable flags wrong");

	property p_port_off;
		@(posedge i_clk) disable iff (i_sys_rst)
		(!i_sys_rst && i_ce) |=> o_usb2_port_disabled == ($past(dp_reg) & $past(dm_reg));
	endproperty
	a_port_off: assert property (p_port_off)
		else $error("port disable not both straps");

	property p_ss_follows;
		@(posedge i_clk) disable iff (i_sys_rst)
		o_ss_port_disabled == o_usb2_port_disabled;
	endproperty
	a_ss_follows: assert property (p_ss_follows)
		else $error("superspeed disable differs");

	sequence s_reset_seen;
		!i_sys_rst && i_ce && rst_active_w;
	endsequence
	property p_core_held;
		@(posedge i_clk) disable iff (i_sys_rst)
		s_reset_seen ##1 i_ce |=> o_core_rst;
	endproperty
	a_core_held: assert property (p_core_held)
		else $error("core not held in reset");

endmodule

// *** sim/rsl_strap_board.sv ***
// Board model: strap resistors and the reset sources seen by the strap latch.
// Assumes one bench process calls its tasks, and that pins change just after a rising edge.
`timescale 1ns/1ps

module rsl_strap_board
(
	// Clock
	input  wire logic       i_clk,
	// Reset pins
	output logic            o_por_n,
	output logic            o_chip_rst_n,
	// Strap pins
	output logic [2:0]      o_mode_strap_level,
	output logic [5:0]      o_port_dplus_off_strap,
	output logic [5:0]      o_port_dminus_off_strap
);

	// ==========================================================
	// Power-up state
	initial
	begin
		o_por_n = 1'b0;
		o_chip_rst_n = 1'b1;
		o_mode_strap_level = 3'h7;
		o_port_dplus_off_strap = 6'h3f;
		o_port_dminus_off_strap = 6'h3f;
	end

	// ==========================================================
	// Pin tasks
	task automatic drive(input logic [2:0] lvl, input logic [5:0] p, input logic [5:0] m);
		@(posedge i_clk);
		o_mode_strap_level <= lvl;
		o_port_dplus_off_strap <= p;
		o_port_dminus_off_strap <= m;
	endtask

	// Straps show the wrong pattern while held, so an early capture is visible
	task automatic hold(input logic use_por, input logic [2:0] lvl, input logic [5:0] p,
		input logic [5:0] m);
		drive(~lvl, ~p, ~m);
		o_por_n <= ~use_por;
		o_chip_rst_n <= use_por;
	endtask

	// Final straps settle well ahead of release; a slow board uses a larger count
	task automatic release_after(input int settle, input logic [2:0] lvl,
		input logic [5:0] p, input logic [5:0] m);
		drive(lvl, p, m);
		repeat (settle) @(posedge i_clk);
		o_por_n <= 1'b1;
		o_chip_rst_n <= 1'b1;
	endtask

endmodule

// *** sim/rsl_strap_latch_bench.sv ***
// Testbench for the strap latch: every mode code, both reset pins, strap hold.
// Assumes the board model drives all pins; outputs are sampled on falling edges.
`timescale 1ns/1ps

module rsl_strap_latch_bench;

	// ==========================================================
	// Signals
	logic               i_clk;
	logic               i_sys_rst;
	logic               i_ce;
	logic               por_n;
	logic               chip_rst_n;
	logic [2:0]         mode_lvl;
	logic [5:0]         dp_strap;
	logic [5:0]         dm_strap;
	logic               o_core_rst;
	logic               o_straps_valid;
	rsl_pkg::rsl_mode_t o_mode;
	logic               o_bridge;
	logic               o_slave;
	logic               o_rsvd;
	logic [5:0]         o_dp;
	logic [5:0]         o_dm;
	logic [5:0]         o_usb2;
	logic [5:0]         o_ss;
	int                 fails;
	int                 check_count;
	int                 cycles;

	rsl_strap_board rsl_strap_board_i
	(
		.i_clk(i_clk), .o_por_n(por_n), .o_chip_rst_n(chip_rst_n),
		.o_mode_strap_level(mode_lvl), .o_port_dplus_off_strap(dp_strap),
		.o_port_dminus_off_strap(dm_strap)
	);

	rsl_strap_latch rsl_strap_latch_i
	(
		.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_por_n(por_n),
		.i_chip_rst_n(chip_rst_n), .i_mode_strap_level(mode_lvl),
		.i_port_dplus_off_strap(dp_strap), .i_port_dminus_off_strap(dm_strap),
		.o_core_rst(o_core_rst), .o_straps_valid(o_straps_valid), .o_mode(o_mode),
		.o_bridge_master_setting(o_bridge), .o_config_slave_setting(o_slave),
		.o_mode_reserved(o_rsvd), .o_dplus_disabled(o_dp), .o_dminus_disabled(o_dm),
		.o_usb2_port_disabled(o_usb2), .o_ss_port_disabled(o_ss)
	);

	// ==========================================================
	// Clock, watchdog, reporting
	initial
	begin
		i_clk = 1'b0;
		i_sys_rst = 1'b1;
		i_ce = 1'b1;
		fails = 0;
		check_count = 0;
		cycles = 0;
	end

	always #4 i_clk = ~i_clk;

	always @(posedge i_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 3000)
		begin
			fails = fails + 1;
			end_of_test();
		end
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count = check_count + 1;
		if (seen !== exp)
		begin
			fails = fails + 1;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test();
		$display("Checks %0d, mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// ==========================================================
	// One reset cycle through the board, then the decoded result
	task automatic run_case(input logic [2:0] lvl, input logic use_por, input logic [5:0] p,
		input logic [5:0] m);
		int n;
		rsl_strap_board_i.hold(use_por, lvl, p, m);
		repeat (8) @(negedge i_clk);
		check(o_core_rst, 1'b1);
		check(o_straps_valid, 1'b0);
		rsl_strap_board_i.release_after(6, lvl, p, m);
		n = 0;
		while (o_straps_valid !== 1'b1 && n < 20)
		begin
			@(negedge i_clk);
			n++;
		end
		check(o_straps_valid, 1'b1);
		check(o_core_rst, 1'b0);
		check(o_mode, (lvl > 3'h5) ? 8'h05 : lvl);
		check(o_bridge, lvl == 3'h0);
		check(o_slave, lvl == 3'h1);
		check(o_rsvd, lvl > 3'h1);
		check(o_dp, p);
		check(o_dm, m);
		check(o_usb2, p & m);
		check(o_ss, p & m);
		$display("Mode code %0d with pin %0d done", lvl, use_por);
	endtask

	// ==========================================================
	// Main sequence
	initial
	begin
		logic [5:0] p;
		logic [5:0] m;
		repeat (10) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		for (int k = 0; k < 8; k++)
		begin
			p = 6'h15 + 6'(k * 5);
			m = 6'h3c - 6'(k * 3);
			run_case(3'(k), k[0], p, m);
		end
		// Later strap changes must not reach the outputs
		rsl_strap_board_i.drive(3'h0, ~p, ~m);
		repeat (20) @(negedge i_clk);
		check(o_mode, 8'h05);
		check(o_dp, p);
		check(o_usb2, p & m);
		check(o_straps_valid, 1'b1);
		$display("Strap hold after lock done");
		// With the enable low the block freezes, even across a pin reset
		@(posedge i_clk);
		i_ce <= 1'b0;
		rsl_strap_board_i.hold(1'b0, 3'h1, 6'h2a, 6'h2b);
		repeat (12) @(negedge i_clk);
		check(o_core_rst, 1'b0);
		check(o_mode, 8'h05);
		check(o_straps_valid, 1'b1);
		@(posedge i_clk);
		i_ce <= 1'b1;
		run_case(3'h1, 1'b0, 6'h2a, 6'h2b);
		// A mid-run system reset clears the outputs, then the straps are taken again
		@(posedge i_clk);
		i_sys_rst <= 1'b1;
		repeat (2) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		@(negedge i_clk);
		check(o_straps_valid, 1'b0);
		check(o_core_rst, 1'b1);
		check(o_dp, 6'h00);
		repeat (12) @(negedge i_clk);
		check(o_straps_valid, 1'b1);
		check(o_slave, 1'b1);
		check(o_usb2, 6'h2a);
		$display("System reset in mid-run done");
		end_of_test();
	end

endmodule
